// >>> logic/stc_pkg.sv
// Constants for the sample time tick counter
//------------------------------------------------------------
//------------------------------------------------------------
package stc_pkg;
  // Register byte addresses
  localparam int             ADR_W     = 8;
  localparam logic [7:0]     CTRL_OFF  = 8'h00;
  localparam logic [7:0]     BYTE0_OFF = 8'h04;
  localparam logic [7:0]     BYTE1_OFF = 8'h08;
  localparam logic [7:0]     BYTE2_OFF = 8'h0C;
  localparam logic [7:0]     BYTE3_OFF = 8'h10;
  localparam logic [7:0]     TRIM_OFF  = 8'h14;
  localparam logic [7:0]     SRC_OFF   = 8'h18;
  localparam logic [7:0]     RATE_OFF  = 8'h1C;
  // Control field positions and reset value
  localparam int             CTL_EN    = 0;
  localparam int             CTL_ACC   = 1;
  localparam int             CTL_GYR   = 2;
  localparam int             CTL_ROUTE = 3;
  localparam int             CTL_BATCH = 4;
  localparam logic [4:0]     CTRL_RST  = 5'h00;
  localparam int             SRC_WRAP  = 0;
  localparam logic [3:0]     RATE_RST  = 4'h0;
  localparam logic [3:0]     RATE_MAX  = 4'hA;
  localparam logic [10:0]    COEFF_TOP = 11'h400;
  // Magic clear key and counter limit
  localparam logic [7:0]     CLEAR_KEY = 8'hAA;
  localparam logic [31:0]    COUNT_MAX = 32'hFFFFFFFF;
  // Timing: figures in ns, cycle counts derived at the clock rate
  localparam int             CLK_MHZ        = 25;
  localparam int             TICK_PERIOD_NS = 21750;
  localparam int             TICK_CYCLES    =
    (TICK_PERIOD_NS * CLK_MHZ + 999) / 1000;
  localparam int             WARN_LEAD_NS   = 5600000;
  localparam int             WARN_TICKS     = WARN_LEAD_NS / TICK_PERIOD_NS;
  localparam int             PULSE_NS       = 65000;
  localparam int             PULSE_CYCLES   = (PULSE_NS * CLK_MHZ + 999) / 1000;
endpackage : stc_pkg

// >>> logic/stc_tick_counter.sv
// Sample time tick counter with Wishbone register access
//
// Register access over Wishbone and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module stc_tick_counter
  import stc_pkg::*;
#(
  parameter logic [7:0] RATE_TRIM = 8'h00  // Factory trim, read only
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  // Wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Sample batching
  input  wire logic             sample_strobe_i,
  output logic      [31:0]      stamp_o,
  output logic                  stamp_valid_o,
  // Interrupt pin 2
  output logic                  irq_pin_2_o
);

  //----------------------------------------------------------
  // State
  //----------------------------------------------------------
  typedef struct packed {
    logic [4:0]  ctl;
    logic [3:0]  rate;
    logic [31:0] count;
    logic [23:0] snap;
    logic        flag;
    logic [9:0]  div;
    logic [10:0] pulse;
    logic        irq2;
    logic        ack;
    logic [31:0] dat;
    logic [31:0] stamp;
    logic        stamp_v;
  } stc_state_type;

  localparam logic [9:0]  DIV_LAST   = 10'(TICK_CYCLES - 1);
  localparam logic [10:0] PULSE_LAST = 11'(PULSE_CYCLES - 1);
  localparam logic [31:0] WARN_AT    = COUNT_MAX - 32'(WARN_TICKS);

  stc_state_type st_reg;
  stc_state_type st_next;

  // Address match, shared by read and write decode
  function automatic logic hit(input logic [ADR_W-1:0] adr,
                               input logic [7:0] off);
    hit = (adr == off);
  endfunction : hit

  logic req;
  logic wr;
  logic rd;
  logic tick;
  logic run;
  logic clr;
  logic warn_set;

  //----------------------------------------------------------
  // Next state
  //----------------------------------------------------------
  always_comb begin
    st_next  = st_reg;
    req      = wb_cyc_i && wb_stb_i && !st_reg.ack;
    wr       = req && wb_we_i;
    rd       = req && !wb_we_i;
    tick     = (st_reg.div == DIV_LAST);
    // Both sensors off stops the timebase view of the counter
    run      = st_reg.ctl[CTL_EN] && (st_reg.ctl[CTL_ACC]
               || st_reg.ctl[CTL_GYR]);
    clr      = wr && wb_sel_i[0] && hit(wb_adr_i, BYTE2_OFF)
               && (wb_dat_i[7:0] == CLEAR_KEY);
    warn_set = 1'b0;

    // Timebase divider, free running so the phase never drifts
    st_next.div = tick ? 10'h000 : st_reg.div + 10'h001;

    // Count: hold when idle, wrap by natural overflow
    if (clr) begin
      st_next.count = 32'h00000000;
    end else if (tick && run) begin
      st_next.count = st_reg.count + 32'h00000001;
      warn_set      = (st_next.count == WARN_AT);
    end

    // Bus answer one cycle after the request, then dropped
    st_next.ack = req;
    st_next.dat = 32'h00000000;
    if (rd) begin
      unique case (1'b1)
        hit(wb_adr_i, CTRL_OFF):
          st_next.dat = {27'h0, st_reg.ctl};
        hit(wb_adr_i, BYTE0_OFF): begin
          st_next.dat  = {24'h0, st_reg.count[7:0]};
          st_next.snap = st_reg.count[31:8];
        end
        hit(wb_adr_i, BYTE1_OFF):
          st_next.dat = {24'h0, st_reg.snap[7:0]};
        hit(wb_adr_i, BYTE2_OFF):
          st_next.dat = {24'h0, st_reg.snap[15:8]};
        hit(wb_adr_i, BYTE3_OFF):
          st_next.dat = {24'h0, st_reg.snap[23:16]};
        hit(wb_adr_i, TRIM_OFF):
          st_next.dat = {24'h0, RATE_TRIM};
        hit(wb_adr_i, SRC_OFF):
          st_next.dat = {31'h0, st_reg.flag};
        hit(wb_adr_i, RATE_OFF):
          st_next.dat = {5'h0, COEFF_TOP >> st_reg.rate,
                         12'h000, st_reg.rate};
        default:
          st_next.dat = 32'h00000000;
      endcase
    end

    // Control writes; the low byte lane carries every field
    if (wr && wb_sel_i[0]) begin
      if (hit(wb_adr_i, CTRL_OFF)) begin
        st_next.ctl = wb_dat_i[4:0];
      end
      if (hit(wb_adr_i, RATE_OFF) && wb_dat_i[3:0] <= RATE_MAX) begin
        st_next.rate = wb_dat_i[3:0];
      end
    end

    // Near-wrap flag: a read clears it, a same-cycle set wins
    if (rd && hit(wb_adr_i, SRC_OFF)) begin
      st_next.flag = 1'b0;
    end
    if (warn_set) begin
      st_next.flag = 1'b1;
    end

    // Single fixed-width pulse on the flag's rising edge
    if (warn_set && !st_reg.flag && st_reg.ctl[CTL_ROUTE]) begin
      st_next.irq2  = 1'b1;
      st_next.pulse = 11'h000;
    end else if (st_reg.irq2) begin
      st_next.pulse = st_reg.pulse + 11'h001;
      if (st_reg.pulse == PULSE_LAST) begin
        st_next.irq2 = 1'b0;
      end
    end

    // Stamp each sample with the current count
    st_next.stamp_v = sample_strobe_i && st_reg.ctl[CTL_BATCH];
    if (sample_strobe_i && st_reg.ctl[CTL_BATCH]) begin
      st_next.stamp = st_reg.count;
    end
  end

  //----------------------------------------------------------
  // Registers
  //----------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg       <= '0;
      st_reg.ctl   <= CTRL_RST;
      st_reg.rate  <= RATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops
  assign wb_dat_o      = st_reg.dat;
  assign wb_ack_o      = st_reg.ack;
  assign stamp_o       = st_reg.stamp;
  assign stamp_valid_o = st_reg.stamp_v;
  assign irq_pin_2_o   = st_reg.irq2;

  //----------------------------------------------------------
  // Assertions
  //----------------------------------------------------------
  // Counts cycles the pin stays high, to check the pulse width
  logic [11:0] hi_cnt;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hi_cnt <= 12'h000;
    end else begin
      hi_cnt <= irq_pin_2_o ? hi_cnt + 12'h001 : 12'h000;
    end
  end

  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_pulse_start;
    warn_set && !st_reg.flag && st_reg.ctl[CTL_ROUTE];
  endsequence

  property p_hold_disabled;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (!st_reg.ctl[CTL_EN] && !clr) |=> $stable(st_reg.count);
  endproperty
  a_hold_disabled: assert property (p_hold_disabled)
    else $error("count moved while disabled");

  property p_frozen;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (!st_reg.ctl[CTL_ACC] && !st_reg.ctl[CTL_GYR] && !clr)
      |=> $stable(st_reg.count);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("count moved with sensors off");

  property p_step;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (tick && run && !clr) |=> st_reg.count == $past(st_reg.count) + 1;
  endproperty
  a_step: assert property (p_step)
    else $error("count did not step on tick");

  property p_wrap;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (tick && run && !clr && st_reg.count == COUNT_MAX)
      |=> st_reg.count == 32'h00000000;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("count did not wrap to zero");

  property p_clear;
    @(posedge mclk_i) disable iff (!rst_n_i)
    clr |=> st_reg.count == 32'h00000000;
  endproperty
  a_clear: assert property (p_clear)
    else $error("magic write did not clear count");

  property p_flag_set;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (tick && run && !clr && st_reg.count == WARN_AT - 1) |=> st_reg.flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("near-wrap flag not set");

  property p_flag_clr;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (rd && hit(wb_adr_i, SRC_OFF) && !warn_set) |=> !st_reg.flag;
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("source read did not clear flag");

  property p_pulse;
    @(posedge mclk_i) disable iff (!rst_n_i)
    s_pulse_start |=> irq_pin_2_o [*8];
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("pulse did not start");

  property p_pulse_len;
    @(posedge mclk_i) disable iff (!rst_n_i)
    $fell(irq_pin_2_o) |-> hi_cnt == 12'(PULSE_CYCLES);
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("pulse width wrong");

  property p_batch;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (sample_strobe_i && st_reg.ctl[CTL_BATCH])
      |=> stamp_valid_o && stamp_o == $past(st_reg.count);
  endproperty
  a_batch: assert property (p_batch)
    else $error("sample not stamped");

  property p_snap;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (rd && hit(wb_adr_i, BYTE3_OFF))
      |=> wb_dat_o == {24'h0, $past(st_reg.snap[23:16])};
  endproperty
  a_snap: assert property (p_snap)
    else $error("byte 3 not from snapshot");

  property p_ack;
    @(posedge mclk_i) disable iff (!rst_n_i)
    s_bus_req |=> s_ack_once;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus answer malformed");

endmodule : stc_tick_counter
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the sample time tick counter
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("wrong value t=%0t got %0h exp %0h", $time, \
  got, exp); end end
module tb;
  import stc_pkg::*;
  typedef struct packed {
    logic [31:0] lo;
    logic [31:0] hi;
  } stc_rng_type;
  // Trim value is arbitrary, only its readback matters
  localparam logic [7:0] TRIM = 8'h5C;
  localparam int         T    = TICK_CYCLES;
  //----------------------------------------------------------
  // Signals
  //----------------------------------------------------------
  logic              mclk_i = 1'b0;
  logic              rst_n_i = 1'b0;
  logic              wb_cyc_i = 1'b0;
  logic              wb_stb_i = 1'b0;
  logic              wb_we_i = 1'b0;
  logic [ADR_W-1:0]  wb_adr_i = 8'h00;
  logic [3:0]        wb_sel_i = 4'h0;
  logic [31:0]       wb_dat_i = 32'h0;
  logic [31:0]       wb_dat_o;
  logic              wb_ack_o;
  logic              sample_strobe_i = 1'b0;
  logic [31:0]       stamp_o;
  logic              stamp_valid_o;
  logic              irq_pin_2_o;
  int                n_mismatch = 0;
  int                n_checks = 0;
  logic [31:0]       seed = 32'hA93D1AAA;
  stc_rng_type       rd_q[$];
  stc_rng_type       st_q[$];
  stc_rng_type       e;
  stc_tick_counter #(.RATE_TRIM(TRIM)) i_stc_tick_counter (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sample_strobe_i(sample_strobe_i),
    .stamp_o(stamp_o), .stamp_valid_o(stamp_valid_o),
    .irq_pin_2_o(irq_pin_2_o));
  // 25 MHz clock
  always #20 mclk_i = ~mclk_i;
  // Shift register source of random data
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // Classic cycle; ack is sampled at the rising edge, release follows it
  task automatic wb_xfer(input logic we, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s,
      input logic [31:0] lo, input logic [31:0] hi);
    int n;
    n = 0;
    if (!we) rd_q.push_back('{lo, hi});
    @(posedge mclk_i);
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we;
    wb_adr_i <= a; wb_dat_i <= d; wb_sel_i <= s;
    do begin
      @(posedge mclk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      n_mismatch++;
      $display("wrong value t=%0t no ack", $time);
    end
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
  endtask : wb_xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_xfer(1'b1, a, d, 4'hF, 32'h0, 32'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] lo,
      input logic [31:0] hi);
    wb_xfer(1'b0, a, 32'h0, 4'hF, lo, hi);
  endtask : rd
  task automatic strobe(input logic exp, input logic [31:0] lo,
      input logic [31:0] hi);
    if (exp) st_q.push_back('{lo, hi});
    @(posedge mclk_i);
    sample_strobe_i <= 1'b1;
    @(posedge mclk_i);
    sample_strobe_i <= 1'b0;
  endtask : strobe
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  //----------------------------------------------------------
  // Monitor: each read answer and each stamp is matched against the oldest note
  //----------------------------------------------------------
  // Sampled at the rising edge, the same edge at which the master takes ack
  always @(posedge mclk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      e = rd_q.pop_front();
      `CHK(wb_dat_o >= e.lo && wb_dat_o <= e.hi, 1'b1)
    end
    if (stamp_valid_o === 1'b1) begin
      `CHK(st_q.size() > 0, 1'b1)
      if (st_q.size() > 0) begin
        e = st_q.pop_front();
        `CHK(stamp_o >= e.lo && stamp_o <= e.hi, 1'b1)
      end
    end
  end
  // Watchdog well beyond the expected run of about 11100 cycles
  initial begin
    repeat (30000) @(posedge mclk_i);
    n_mismatch++;
    final_report();
  end
  //----------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------
  initial begin
    logic [31:0] v;
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(CTRL_OFF, 32'h0, 32'h0);
    rd(RATE_OFF, {16'(COEFF_TOP), 16'h0}, {16'(COEFF_TOP), 16'h0});
    rd(TRIM_OFF, {24'h0, TRIM}, {24'h0, TRIM});
    rd(8'h40, 32'h0, 32'h0);
    rd(SRC_OFF, 32'h0, 32'h0);
    // Read-only places keep their contents against random data, control against a write without the low byte lane
    seed = lfsr_next(seed);
    wr(BYTE0_OFF, {seed[31:8], 8'h11});
    wr(TRIM_OFF, seed);
    wb_xfer(1'b1, CTRL_OFF, 32'h1F, 4'hE, 32'h0, 32'h0);
    rd(TRIM_OFF, {24'h0, TRIM}, {24'h0, TRIM});
    rd(CTRL_OFF, 32'h0, 32'h0);
    rd(BYTE0_OFF, 32'h0, 32'h0);
    $display("test reset and read-only done");
    // Every rate step, then one step out of range that is ignored
    for (int s = 0; s <= 11; s++) begin
      wr(RATE_OFF, 32'(s));
      v = (s <= 10) ? ({16'(COEFF_TOP >> s), 16'(s)})
                    : ({16'(COEFF_TOP >> 10), 16'd10});
      rd(RATE_OFF, v, v);
    end
    $display("test rate steps done");
    // Enabled but both sensors off, then powered but disabled
    wr(CTRL_OFF, 32'h01);
    repeat (3 * T) @(posedge mclk_i);
    rd(BYTE0_OFF, 32'h0, 32'h0);
    wr(CTRL_OFF, 32'h02);
    repeat (3 * T) @(posedge mclk_i);
    rd(BYTE0_OFF, 32'h0, 32'h0);
    $display("test freeze done");
    // Run with accelerometer and batching; divider phase is free
    wr(CTRL_OFF, 32'h13);
    repeat (5 * T) @(posedge mclk_i);
    rd(BYTE0_OFF, 32'd4, 32'd6);
    rd(BYTE1_OFF, 32'h0, 32'h0);
    rd(BYTE2_OFF, 32'h0, 32'h0);
    rd(BYTE3_OFF, 32'h0, 32'h0);
    strobe(1'b1, 32'd4, 32'd7);
    strobe(1'b1, 32'd4, 32'd7);
    $display("test counting and batching done");
    // Disable holds the count, then gyroscope alone resumes it
    wr(CTRL_OFF, 32'h06);
    repeat (4 * T) @(posedge mclk_i);
    rd(BYTE0_OFF, 32'd4, 32'd7);
    wr(CTRL_OFF, 32'h05);
    repeat (3 * T) @(posedge mclk_i);
    rd(BYTE0_OFF, 32'd6, 32'd11);
    strobe(1'b0, 32'h0, 32'h0);
    $display("test hold and resume done");
    // Key write clears the whole count while it runs
    wr(BYTE2_OFF, {24'h0, CLEAR_KEY});
    rd(BYTE0_OFF, 32'h0, 32'h1);
    rd(BYTE2_OFF, 32'h0, 32'h0);
    rd(SRC_OFF, 32'h0, 32'h0);
    `CHK(irq_pin_2_o, 1'b0)
    repeat (5) @(posedge mclk_i);
    `CHK(st_q.size(), 0)
    $display("test clear done");
    // Control readback, then a mid-run reset restores every reset value
    wr(CTRL_OFF, 32'h0F);
    rd(CTRL_OFF, 32'h0F, 32'h0F);
    repeat (2 * T) @(posedge mclk_i);
    `CHK(irq_pin_2_o, 1'b0)
    rst_n_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(CTRL_OFF, 32'h0, 32'h0);
    rd(RATE_OFF, {16'(COEFF_TOP), 16'h0}, {16'(COEFF_TOP), 16'h0});
    rd(BYTE0_OFF, 32'h0, 32'h0);
    rd(SRC_OFF, 32'h0, 32'h0);
    $display("test mid-run reset done");
    final_report();
  end
endmodule : tb
`default_nettype wire
